//--- spec_host.sv
// Host adapter model driving the task-file registers over APB
`timescale 1ns/1ps
module spec_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	int timeouts;

	// Idle bus from time zero
	initial begin
		psel     = 1'b0;
		penable  = 1'b0;
		pwrite   = 1'b0;
		paddr    = 8'h00;
		pwdata   = 32'h0000_0000;
		timeouts = 0;
	end

	// ------------------------------------------------------------
	// One transfer, held until ready is sampled high
	// ------------------------------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64) timeouts++;
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Released data flips so stale values cannot pass
		pwdata  <= ~d;
	endtask

	// Whole sector: control word, password words, reserved zeros
	task automatic send_block(input logic [15:0] ctl, input logic [15:0] pw);
		logic [31:0] q;
		logic        e;
		for (int w = 0; w < spec_pkg::BLOCK_WORDS; w++) begin
			xfer(1'b1, spec_pkg::OFF_DATA, {16'h0000, w == 0 ? ctl : (w <= spec_pkg::PW_LAST ?
				pw + 16'(w - 1) : 16'h0000)}, q, e);
		end
	endtask
endmodule // spec_host

//--- spec_pkg.sv
// Package for the security command interpreter: offsets, fields, codes and types
package spec_pkg;

	// ------------------------------------------------------------
	// Register byte offsets on APB
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_ERROR    = 8'h00;
	localparam logic [7:0] OFF_SECCNT   = 8'h04;
	localparam logic [7:0] OFF_SECNUM   = 8'h08;
	localparam logic [7:0] OFF_CYLLO    = 8'h0C;
	localparam logic [7:0] OFF_CYLHI    = 8'h10;
	localparam logic [7:0] OFF_DEVHEAD  = 8'h14;
	localparam logic [7:0] OFF_STATUS   = 8'h18;
	localparam logic [7:0] OFF_COMMAND  = 8'h1C;
	localparam logic [7:0] OFF_FEATURE  = 8'h20;
	localparam logic [7:0] OFF_DATA     = 8'h24;
	localparam logic [7:0] OFF_CONFIG   = 8'h28;
	localparam logic [7:0] OFF_SECSTATE = 8'h2C;
	localparam logic [7:0] OFF_USER_PW  = 8'h30;
	localparam logic [7:0] OFF_MASTER_PW = 8'h34;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h38;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h3C;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_BUSY  = 7;
	localparam int BIT_READY = 6;
	localparam int BIT_FAULT = 5;
	localparam int BIT_XFER_REQ = 3;
	localparam int BIT_ERR   = 0;
	localparam int BIT_ABORT = 2;
	localparam int BIT_DEV   = 4;
	localparam int BIT_PW_ID = 0;
	localparam int BIT_EMODE = 1;
	localparam int PW_IDX_LSB = 16;
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_ERROR = 1;
	localparam int IRQ_W     = 2;

	// ------------------------------------------------------------
	// Command codes and block layout
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_DISABLE_PW = 8'hF6;
	localparam logic [7:0] CMD_ERASE_ARM  = 8'hF3;
	localparam logic [7:0] CMD_ERASE_UNIT = 8'hF4;
	localparam int BLOCK_WORDS = 256;
	localparam int PW_FIRST    = 1;
	localparam int PW_LAST     = 16;
	localparam int PW_WORDS    = 16;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;
	localparam logic [15:0] RST_PW     = 16'h0000;
	localparam logic [8:0]  RST_WCNT   = 9'h000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DATA = 2'b01,
		ST_EXEC = 2'b10
	} spec_state_t;

	// Software-owned environment bits
	typedef struct packed {
		logic overwrite_fail;
		logic dev_fault;
		logic frozen;
		logic dev_id;
		logic supported;
	} spec_cfg_t;

	// Completion byte as the host sees it
	typedef struct packed {
		logic busy;
		logic ready;
		logic fault;
		logic rsv4;
		logic xfer_req;
		logic rsv2;
		logic rsv1;
		logic err;
	} spec_status_t;

endpackage

//--- spec_top.sv
// Security password and erase command interpreter with APB register access
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
module spec_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq
);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic wr_en;
	logic rd_en;
	logic mapped;

	// Zero-wait slave, so every access ends in its first access cycle
	assign pready = 1'b1;
	assign wr_en  = psel && penable && pwrite;
	assign rd_en  = psel && penable && !pwrite;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a[1:0] == 2'b00) && (a <= spec_pkg::OFF_IRQ_MASK);
	endfunction

	assign mapped  = is_mapped(paddr);
	assign pslverr = psel && penable && !mapped;

	function automatic logic wr_at(input logic en, input logic [7:0] a,
			input logic [7:0] off);
		wr_at = en && (a == off);
	endfunction

	// ------------------------------------------------------------
	// State declarations
	// ------------------------------------------------------------
	localparam logic [7:0] RST_CMD_NONE = spec_pkg::RST_BYTE;
	spec_pkg::spec_state_t state_q;
	spec_pkg::spec_cfg_t   cfg_q;
	logic [7:0]  sec_cnt_q;
	logic [7:0]  sec_num_q;
	logic [7:0]  cyl_lo_q;
	logic [7:0]  cyl_hi_q;
	logic [7:0]  devhead_q;
	logic [7:0]  feature_q;
	logic [7:0]  cmd_q;
	logic        abort_q;
	logic        abort_now;
	logic        fault_q;
	logic        busy_q;
	logic        xfer_req_q;
	logic        armed_q;
	logic        lock_en_q;
	logic        locked_q;
	logic        master_set_q;
	logic        emode_q;
	logic        emode_last_q;
	logic        pw_id_q;
	logic        miss_user_q;
	logic        miss_master_q;
	logic [8:0]  wcnt_q;
	logic [15:0] user_pw_q [spec_pkg::PW_WORDS];
	logic [15:0] master_pw_q [spec_pkg::PW_WORDS];
	logic [spec_pkg::IRQ_W-1:0] irq_stat_q;
	logic [spec_pkg::IRQ_W-1:0] irq_mask_q;
	logic [spec_pkg::IRQ_W-1:0] irq_set;
	logic        done_pulse;
	logic        cmd_wr;
	logic        accept;
	logic        data_wr;
	logic        last_word;
	logic        pw_word;
	logic [3:0]  pw_idx;
	logic        match;
	logic        exec_fail;

	// ------------------------------------------------------------
	// Command acceptance
	// ------------------------------------------------------------
	// Commands for the other device, or while busy or in data, are dropped
	assign cmd_wr = wr_at(wr_en, paddr, spec_pkg::OFF_COMMAND);
	assign accept = cmd_wr && (state_q == spec_pkg::ST_IDLE)
		&& (devhead_q[spec_pkg::BIT_DEV] == cfg_q.dev_id);

	// Early abort decided from the code, the supported bit and security state alone
	always_comb begin
		abort_now = 1'b0;
		if (!cfg_q.supported) begin
			abort_now = 1'b1;
		end else begin
			unique case (pwdata[7:0])
				spec_pkg::CMD_DISABLE_PW: abort_now = locked_q || cfg_q.frozen;
				spec_pkg::CMD_ERASE_ARM:  abort_now = cfg_q.frozen;
				spec_pkg::CMD_ERASE_UNIT: abort_now = cfg_q.frozen || !armed_q;
				default:                  abort_now = 1'b1;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Data phase helpers
	// ------------------------------------------------------------
	assign data_wr   = wr_at(wr_en, paddr, spec_pkg::OFF_DATA) && (state_q == spec_pkg::ST_DATA);
	assign last_word = (wcnt_q == 9'(spec_pkg::BLOCK_WORDS - 1));
	assign pw_word   = (wcnt_q >= 9'(spec_pkg::PW_FIRST)) && (wcnt_q <= 9'(spec_pkg::PW_LAST));
	assign pw_idx    = 4'(wcnt_q - 9'(spec_pkg::PW_FIRST));
	assign match     = pw_id_q ? !miss_master_q : !miss_user_q;

	// Outcome at execution end
	always_comb begin
		exec_fail = 1'b0;
		if (cmd_q == spec_pkg::CMD_DISABLE_PW) begin
			exec_fail = !match;
		end else if (cmd_q == spec_pkg::CMD_ERASE_UNIT) begin
			exec_fail = !match || cfg_q.overwrite_fail;
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// Data commands ask for exactly one sector, prepare skips the data phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= spec_pkg::ST_IDLE;
			wcnt_q  <= spec_pkg::RST_WCNT;
		end else begin
			unique case (state_q)
				spec_pkg::ST_IDLE: begin
					wcnt_q <= spec_pkg::RST_WCNT;
					if (accept && !abort_now && pwdata[7:0] != spec_pkg::CMD_ERASE_ARM) begin
						state_q <= spec_pkg::ST_DATA;
					end else if (accept) begin
						state_q <= spec_pkg::ST_EXEC;
					end
				end
				spec_pkg::ST_DATA: begin
					if (data_wr) begin
						wcnt_q <= wcnt_q + 9'h001;
						if (last_word) begin
							state_q <= spec_pkg::ST_EXEC;
						end
					end
				end
				spec_pkg::ST_EXEC: begin
					state_q <= spec_pkg::ST_IDLE;
				end
				default: begin
					state_q <= spec_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Busy and transfer request as the host reads them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q     <= 1'b0;
			xfer_req_q <= 1'b0;
		end else begin
			busy_q     <= 1'b0;
			xfer_req_q <= 1'b0;
			if (accept) begin
				busy_q <= 1'b1;
			end else if (state_q == spec_pkg::ST_IDLE && cmd_q != RST_CMD_NONE) begin
				busy_q <= 1'b0;
			end
			if (state_q == spec_pkg::ST_IDLE && accept && !abort_now
					&& pwdata[7:0] != spec_pkg::CMD_ERASE_ARM) begin
				xfer_req_q <= 1'b1;
			end else if (state_q == spec_pkg::ST_DATA && !(data_wr && last_word)) begin
				xfer_req_q <= 1'b1;
			end
			if (state_q == spec_pkg::ST_DATA) begin
				busy_q <= data_wr && last_word;
			end
		end
	end

	// ------------------------------------------------------------
	// Password block capture
	// ------------------------------------------------------------
	// Comparing on the fly avoids buffering the whole sector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pw_id_q       <= 1'b0;
			emode_q       <= 1'b0;
			miss_user_q   <= 1'b0;
			miss_master_q <= 1'b0;
		end else if (accept) begin
			miss_user_q   <= 1'b0;
			miss_master_q <= 1'b0;
		end else if (data_wr) begin
			if (wcnt_q == spec_pkg::RST_WCNT) begin
				pw_id_q <= pwdata[spec_pkg::BIT_PW_ID];
				emode_q <= pwdata[spec_pkg::BIT_EMODE];
			end else if (pw_word) begin
				if (pwdata[15:0] != user_pw_q[pw_idx]) begin
					miss_user_q <= 1'b1;
				end
				if (pwdata[15:0] != master_pw_q[pw_idx]) begin
					miss_master_q <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Stored passwords
	// ------------------------------------------------------------
	// Software loads them word by word; no command ever writes master
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < spec_pkg::PW_WORDS; i++) begin
				user_pw_q[i]   <= spec_pkg::RST_PW;
				master_pw_q[i] <= spec_pkg::RST_PW;
			end
		end else begin
			if (wr_at(wr_en, paddr, spec_pkg::OFF_USER_PW)) begin
				user_pw_q[pwdata[spec_pkg::PW_IDX_LSB+:4]] <= pwdata[15:0];
			end
			if (wr_at(wr_en, paddr, spec_pkg::OFF_MASTER_PW)) begin
				master_pw_q[pwdata[spec_pkg::PW_IDX_LSB+:4]] <= pwdata[15:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Security state
	// ------------------------------------------------------------
	// Lock function, locked mode, erase arming and last erase mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_en_q    <= 1'b0;
			locked_q     <= 1'b0;
			master_set_q <= 1'b0;
			armed_q      <= 1'b0;
			emode_last_q <= 1'b0;
		end else begin
			if (wr_at(wr_en, paddr, spec_pkg::OFF_USER_PW)) begin
				lock_en_q <= 1'b1;
			end
			if (wr_at(wr_en, paddr, spec_pkg::OFF_MASTER_PW)) begin
				master_set_q <= 1'b1;
			end
			// Software may lock only while a user password is active
			if (wr_at(wr_en, paddr, spec_pkg::OFF_SECSTATE) && lock_en_q) begin
				locked_q <= pwdata[1];
			end
			if (accept) begin
				armed_q <= (pwdata[7:0] == spec_pkg::CMD_ERASE_ARM) && !abort_now;
			end
			if (state_q == spec_pkg::ST_EXEC && !abort_q && !exec_fail) begin
				if (cmd_q == spec_pkg::CMD_DISABLE_PW) begin
					lock_en_q <= 1'b0;
				end
				if (cmd_q == spec_pkg::CMD_ERASE_UNIT) begin
					lock_en_q    <= 1'b0;
					locked_q     <= 1'b0;
					emode_last_q <= emode_q;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Completion flags
	// ------------------------------------------------------------
	// Abort takes the early abort decision when a command is taken and is set at its end on failure
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_q   <= RST_CMD_NONE;
			abort_q <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			if (accept) begin
				cmd_q   <= pwdata[7:0];
				abort_q <= abort_now;
				fault_q <= 1'b0;
			end else if (state_q == spec_pkg::ST_EXEC) begin
				if (exec_fail || abort_q) begin
					abort_q <= 1'b1;
					fault_q <= cfg_q.dev_fault;
				end else begin
					fault_q <= 1'b0;
				end
			end
		end
	end

	assign done_pulse = (state_q == spec_pkg::ST_EXEC);

	// ------------------------------------------------------------
	// Task-file and configuration registers
	// ------------------------------------------------------------
	// These bytes are stored for the host; only the device bit of devhead_q and the configuration steer anything here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_cnt_q <= spec_pkg::RST_BYTE;
			sec_num_q <= spec_pkg::RST_BYTE;
			cyl_lo_q  <= spec_pkg::RST_BYTE;
			cyl_hi_q  <= spec_pkg::RST_BYTE;
			devhead_q <= spec_pkg::RST_BYTE;
			feature_q <= spec_pkg::RST_BYTE;
			cfg_q     <= '0;
		end else begin
			if (wr_at(wr_en, paddr, spec_pkg::OFF_SECCNT))  sec_cnt_q <= pwdata[7:0];
			if (wr_at(wr_en, paddr, spec_pkg::OFF_SECNUM))  sec_num_q <= pwdata[7:0];
			if (wr_at(wr_en, paddr, spec_pkg::OFF_CYLLO))   cyl_lo_q  <= pwdata[7:0];
			if (wr_at(wr_en, paddr, spec_pkg::OFF_CYLHI))   cyl_hi_q  <= pwdata[7:0];
			if (wr_at(wr_en, paddr, spec_pkg::OFF_DEVHEAD)) devhead_q <= pwdata[7:0];
			if (wr_at(wr_en, paddr, spec_pkg::OFF_FEATURE)) feature_q <= pwdata[7:0];
			if (wr_at(wr_en, paddr, spec_pkg::OFF_CONFIG)) begin
				cfg_q <= spec_pkg::spec_cfg_t'(pwdata[4:0]);
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	// Set wins over the read that clears, so no completion is lost
	assign irq_set = {done_pulse && (exec_fail || abort_q), done_pulse};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			irq        <= 1'b0;
		end else begin
			if (wr_at(wr_en, paddr, spec_pkg::OFF_IRQ_MASK)) begin
				irq_mask_q <= pwdata[spec_pkg::IRQ_W-1:0];
			end
			if (rd_en && paddr == spec_pkg::OFF_IRQ_STAT) begin
				// Only reported bits clear; an event at the setup edge survives
				irq_stat_q <= (irq_stat_q & ~prdata[spec_pkg::IRQ_W-1:0]) | irq_set;
			end else begin
				irq_stat_q <= irq_stat_q | irq_set;
			end
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	spec_pkg::spec_status_t stat;
	logic [7:0] err_byte;

	// Error bit mirrors any set error-register bit
	always_comb begin
		err_byte = spec_pkg::RST_BYTE;
		err_byte[spec_pkg::BIT_ABORT] = abort_q && !busy_q;
		stat = '0;
		stat.busy     = busy_q;
		stat.ready    = !busy_q;
		stat.fault    = fault_q && !busy_q;
		stat.xfer_req = xfer_req_q;
		stat.err   = |err_byte;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= spec_pkg::RST_WORD;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				spec_pkg::OFF_ERROR:    prdata <= {24'h00_0000, err_byte};
				spec_pkg::OFF_SECCNT:   prdata <= {24'h00_0000, sec_cnt_q};
				spec_pkg::OFF_SECNUM:   prdata <= {24'h00_0000, sec_num_q};
				spec_pkg::OFF_CYLLO:    prdata <= {24'h00_0000, cyl_lo_q};
				spec_pkg::OFF_CYLHI:    prdata <= {24'h00_0000, cyl_hi_q};
				spec_pkg::OFF_DEVHEAD:  prdata <= {24'h00_0000, devhead_q};
				spec_pkg::OFF_STATUS:   prdata <= {24'h00_0000, stat};
				spec_pkg::OFF_CONFIG:   prdata <= {27'h000_0000, cfg_q};
				spec_pkg::OFF_SECSTATE: prdata <= {26'h000_0000, emode_last_q, armed_q,
					master_set_q, cfg_q.frozen, locked_q, lock_en_q};
				spec_pkg::OFF_IRQ_STAT: prdata <= {30'h0000_0000, irq_stat_q};
				spec_pkg::OFF_IRQ_MASK: prdata <= {30'h0000_0000, irq_mask_q};
				default:                prdata <= spec_pkg::RST_WORD;
			endcase
		end
	end

endmodule // spec_top

//--- spec_top_monitor.sv
// Port checker for the security command interpreter
`timescale 1ns/1ps
module spec_top_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq
);
	logic       acc;
	logic       st_rd;
	logic       clr;
	logic       arm_wr;
	logic       unit_wr;
	logic [3:0] arm_age_q;
	logic [3:0] unit_age_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------
	// Decode of completed bus transfers
	// ------------------------------------------------------------
	assign acc     = psel && penable;
	assign st_rd   = acc && !pwrite && paddr == spec_pkg::OFF_STATUS;
	assign clr     = acc && (pwrite ? paddr == spec_pkg::OFF_IRQ_MASK : paddr == spec_pkg::OFF_IRQ_STAT);
	assign arm_wr  = acc && pwrite && paddr == spec_pkg::OFF_COMMAND && pwdata[7:0] == spec_pkg::CMD_ERASE_ARM;
	assign unit_wr = acc && pwrite && paddr == spec_pkg::OFF_COMMAND && pwdata[7:0] == spec_pkg::CMD_ERASE_UNIT;

	// Ages since command writes; saturate so old writes leave the window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_age_q  <= 4'hF;
			unit_age_q <= 4'hF;
		end else begin
			arm_age_q  <= arm_wr ? 4'h0 : arm_age_q + {3'b000, arm_age_q != 4'hF};
			unit_age_q <= unit_wr ? 4'h0 : unit_age_q + {3'b000, unit_age_q != 4'hF};
		end
	end

	// Status read with the busy flag clear
	sequence st_done_s;
		st_rd && !prdata[7];
	endsequence

	status_err_a: assert property (st_rd && prdata[0] |-> prdata[6] && !prdata[7] && !prdata[3])
		else $error("error ending shows wrong status flags");
	fault_err_a: assert property (st_rd && prdata[5] |-> prdata[0])
		else $error("fault flag without error flag");
	abort_only_a: assert property (acc && !pwrite && paddr == spec_pkg::OFF_ERROR |-> (prdata & ~32'h0000_0004) == 0)
		else $error("error register shows a bit other than abort");
	arm_no_data_a: assert property (st_done_s ##0 (arm_age_q inside {[1:6]}) |-> !prdata[3])
		else $error("erase prepare asked for data");
	unit_data_a: assert property (st_done_s ##0 (!prdata[0] && unit_age_q inside {[2:6]}) |-> prdata[3])
		else $error("erase unit did not ask for its sector");
	irq_drop_a: assert property ($fell(irq) |-> $past(clr, 1) || $past(clr, 2))
		else $error("interrupt dropped without clear or mask");
	bus_error_a: assert property (acc |-> pslverr == (paddr > 8'h3C || paddr[1:0] != 2'b00))
		else $error("slave error does not match address map");
	unmapped_zero_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0000_0000)
		else $error("unmapped read returned data");
	ready_now_a: assert property (acc |-> pready)
		else $error("access phase without ready");
endmodule // spec_top_monitor

bind spec_top spec_top_monitor i_spec_top_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

//--- testbench.sv
// Self-checking testbench for the security command interpreter
`timescale 1ns/1ps
module testbench;
	localparam logic [7:0] A_ST = spec_pkg::OFF_STATUS;
	localparam logic [7:0] A_ER = spec_pkg::OFF_ERROR;
	localparam logic [7:0] A_CF = spec_pkg::OFF_CONFIG;
	localparam logic [7:0] A_SS = spec_pkg::OFF_SECSTATE;
	localparam logic [7:0] A_IS = spec_pkg::OFF_IRQ_STAT;
	localparam logic [7:0] A_IM = spec_pkg::OFF_IRQ_MASK;
	localparam logic [7:0] ARM  = spec_pkg::CMD_ERASE_ARM;
	localparam logic [7:0] DPW  = spec_pkg::CMD_DISABLE_PW;
	localparam logic [7:0] UNIT = spec_pkg::CMD_ERASE_UNIT;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [31:0] rd_q;
	logic        rd_err;
	int          err_total;
	int          comparisons;

	// Clock
	initial pclk = 1'b0;
	always #2.5 pclk = ~pclk;

	spec_top i_spec_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	spec_host i_spec_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// A hung transfer ends the run
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		i_spec_host.xfer(w, a, d, rd_q, rd_err);
		if (i_spec_host.timeouts > 0) begin
			err_total++;
			finish_test();
		end
	endtask

	task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd_q);
	endtask

	// Poll status until not busy; data request may end the wait
	task automatic poll(input logic dq);
		int n;
		n = 0;
		do begin
			bus(1'b0, A_ST, 32'h0000_0000);
			n++;
		end while ((rd_q[7] !== 1'b0 || (!dq && rd_q[3] !== 1'b0)) && n < 40);
		if (n >= 40) begin
			err_total++;
			finish_test();
		end
	endtask

	// Command, sector if requested, then ending status and error
	task automatic run(input logic [7:0] c, input logic [15:0] ctl, input logic [15:0] pw, input logic [7:0] es);
		bus(1'b1, spec_pkg::OFF_COMMAND, 32'(c));
		poll(1'b1);
		if (rd_q[3] === 1'b1) begin
			i_spec_host.send_block(ctl, pw);
			poll(1'b0);
		end
		chk("status", 32'(es), rd_q);
		chk_rd("error", A_ER, es[0] ? 32'h0000_0004 : 32'h0000_0000);
	endtask

	task automatic set_pw(input logic [7:0] a, input logic [15:0] b);
		for (int i = 0; i < spec_pkg::PW_WORDS; i++) bus(1'b1, a, {12'h000, 4'(i), b + 16'(i)});
	endtask

	// Interrupt level after its one-cycle lag
	task automatic irq_is(input logic e);
		repeat (2) @(posedge pclk);
		#1 chk("irq", 32'(e), 32'(irq));
	endtask

	// Main sequence
	initial begin
		err_total   = 0;
		comparisons = 0;
		presetn     = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		chk_rd("status", A_ST, 32'h0000_0040);
		chk_rd("config", A_CF, 32'h0000_0000);
		chk_rd("secstate", A_SS, 32'h0000_0000);
		chk_rd("irq_stat", A_IS, 32'h0000_0000);
		chk_rd("unmapped", 8'h40, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, 32'(rd_err));
		$display("test reset done");
		bus(1'b1, A_IM, 32'h0000_0003);
		run(ARM, 16'h0000, 16'h0000, 8'h41);
		irq_is(1'b1);
		chk_rd("irq_stat", A_IS, 32'h0000_0003);
		irq_is(1'b0);
		run(DPW, 16'h0000, 16'h0000, 8'h41);
		run(UNIT, 16'h0000, 16'h0000, 8'h41);
		bus(1'b1, A_CF, 32'h0000_0008);
		run(ARM, 16'h0000, 16'h0000, 8'h61);
		$display("test unsupported done");
		bus(1'b1, A_CF, 32'h0000_0001);
		for (int a = 4; a <= 16; a += 4) bus(1'b1, 8'(a), 32'h0000_00FF);
		bus(1'b1, spec_pkg::OFF_FEATURE, 32'h0000_00FF);
		bus(1'b1, spec_pkg::OFF_DEVHEAD, 32'h0000_00EF);
		bus(1'b1, A_IM, 32'h0000_0000);
		chk_rd("irq_stat", A_IS, 32'h0000_0003);
		run(ARM, 16'h0000, 16'h0000, 8'h40);
		irq_is(1'b0);
		chk_rd("secstate", A_SS, 32'h0000_0010);
		bus(1'b1, A_IM, 32'h0000_0003);
		irq_is(1'b1);
		chk_rd("irq_stat", A_IS, 32'h0000_0001);
		irq_is(1'b0);
		bus(1'b1, spec_pkg::OFF_DEVHEAD, 32'h0000_0010);
		bus(1'b1, spec_pkg::OFF_COMMAND, 32'(DPW));
		chk_rd("secstate", A_SS, 32'h0000_0010);
		chk_rd("status", A_ST, 32'h0000_0040);
		bus(1'b1, spec_pkg::OFF_DEVHEAD, 32'h0000_0000);
		$display("test prepare done");
		set_pw(spec_pkg::OFF_USER_PW, 16'hA500);
		set_pw(spec_pkg::OFF_MASTER_PW, 16'h5A00);
		run(DPW, 16'h0001, 16'hA500, 8'h41);
		bus(1'b0, A_ST, 32'h0000_0000);
		chk("ready", 32'h0000_0001, 32'(rd_q[6]));
		run(DPW, 16'hFFFE, 16'hA500, 8'h40);
		chk_rd("secstate", A_SS, 32'h0000_0008);
		run(UNIT, 16'h0000, 16'hA500, 8'h41);
		$display("test password done");
		bus(1'b1, A_CF, 32'h0000_0005);
		run(ARM, 16'h0000, 16'h0000, 8'h41);
		run(DPW, 16'h0000, 16'hA500, 8'h41);
		bus(1'b1, A_CF, 32'h0000_0001);
		set_pw(spec_pkg::OFF_USER_PW, 16'hA500);
		bus(1'b1, A_SS, 32'h0000_0002);
		run(DPW, 16'h0000, 16'hA500, 8'h41);
		run(ARM, 16'h0000, 16'h0000, 8'h40);
		run(UNIT, 16'h0000, 16'h1234, 8'h41);
		bus(1'b1, A_CF, 32'h0000_0011);
		run(ARM, 16'h0000, 16'h0000, 8'h40);
		run(UNIT, 16'h0000, 16'hA500, 8'h41);
		bus(1'b1, A_CF, 32'h0000_0001);
		run(ARM, 16'h0000, 16'h0000, 8'h40);
		run(UNIT, 16'h0003, 16'h5A00, 8'h40);
		chk_rd("secstate", A_SS, 32'h0000_0028);
		$display("test erase done");
		finish_test();
	end
endmodule // testbench
